// File: rtl/counter_io_regs.svh
`ifndef COUNTER_IO_REGS_SVH
`define COUNTER_IO_REGS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CIO_CTRL_ADDR 12'h000
`define CIO_STATUS_ADDR 12'h004
`define CIO_WDOG_ADDR 12'h008
`define CIO_OUTCFG_ADDR 12'h00C
`define CIO_XFER_ADDR 12'h010
// Resource page 0x040-0x07F, index in address bits 5:4
`define CIO_RES_PAGE 6'h01
`define CIO_RES_CFG 2'h0
`define CIO_RES_SETPOINT 2'h1
`define CIO_RES_VALUE 2'h2
`define CIO_RES_SCALED 2'h3
// ----------------------------------------
// Fields
// ----------------------------------------
`define CIO_CTRL_MODE 1:0
`define CIO_CTRL_WDT_CLR 8
`define CIO_CMD_PROGRAM 2'h0
`define CIO_CMD_RUN 2'h1
`define CIO_CMD_BOOT 2'h2
`define CIO_CFG_FUNC 2:0
`define CIO_CFG_RATE 3
`define CIO_CFG_INH_EN 4
`define CIO_CFG_INH_PIN 6:5
`define CIO_CFG_RST_EN 7
`define CIO_CFG_RST_PIN 9:8
`define CIO_CFG_MULT 31:16
`define CIO_OC_SLOT 8
`define CIO_OC_PULSE 0
`define CIO_OC_SRC 2:1
`define CIO_OC_RAW_LVL 3
`define CIO_OC_RAW_EN 4
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CIO_CFG_RESET 32'h01000000
`define CIO_SETPOINT_RESET 32'h00000000
`define CIO_OUTCFG_RESET 32'h00000000
`define CIO_CLK_MHZ 125
`define CIO_CLK_NS 8
`define CIO_TICK_NS 1000
`define CIO_BLINK_HALF_MS 250
`define CIO_WDT_MS 100
`define CIO_RATE_WINDOW_US 1000
`define CIO_PULSE_US 10
`define CIO_SCALE_SHIFT 8
`endif

// File: rtl/counter_io_pkg.sv
package counter_io_pkg;
    typedef enum logic [1:0] {MODE_PROGRAM, MODE_RUN, MODE_BOOT} mode_t;
    typedef enum logic [2:0] {FUNC_OFF, FUNC_QUAD, FUNC_UP, FUNC_DOWN, FUNC_TIMER} func_t;
endpackage

// File: rtl/counter_resource.sv
`timescale 1ns/100ps
`default_nettype none
`include "counter_io_regs.svh"
module counter_resource
    import counter_io_pkg::*;
#(
    parameter int TICK_CYCLES = `CIO_TICK_NS / `CIO_CLK_NS,
    parameter int WINDOW_US = `CIO_RATE_WINDOW_US
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic run_i,
    input wire logic [2:0] func_i,
    input wire logic rate_sel_i,
    input wire logic [15:0] mult_i,
    input wire logic in_a_i,
    input wire logic in_b_i,
    input wire logic inhibit_i,
    input wire logic clear_i,
    input wire logic [31:0] setpoint_i,
    output logic [31:0] value_o,
    output logic [31:0] scaled_o,
    output logic match_o,
    output logic active_o
);
    logic a_q, b_q;
    logic [31:0] count_q, count_d, base_q, rate_q, us_q, interval_q, win_q;
    logic [7:0] tick_q;
    func_t func_w;
    assign func_w = func_t'(func_i);
    // ----------------------------------------
    // Edge decode and counting
    // ----------------------------------------
    wire rise_a = in_a_i & ~a_q;
    wire edge_ab = (in_a_i ^ a_q) | (in_b_i ^ b_q);
    wire timer = func_w == FUNC_TIMER;
    wire hold = ~run_i | inhibit_i;
    wire updown = (func_w == FUNC_UP) | (func_w == FUNC_DOWN);
    wire step = ~hold & (func_w == FUNC_QUAD ? edge_ab : updown & rise_a);
    wire up = func_w == FUNC_QUAD ? a_q ^ in_b_i : func_w == FUNC_UP;
    wire tick = tick_q == 8'(TICK_CYCLES - 1);
    wire win_end = tick & (win_q == 32'(WINDOW_US - 1));
    assign count_d = clear_i ? 32'h00000000 :
        step ? (up ? count_q + 32'h00000001 : count_q - 32'h00000001) : count_q;
    // Position, rate or interval, then engineering scaling
    wire [31:0] raw = timer ? interval_q : rate_sel_i ? rate_q : count_q;
    wire signed [48:0] prod = $signed(raw) * $signed({1'b0, mult_i});
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            count_q <= 32'h00000000;
            tick_q <= 8'h00;
        end else begin
            a_q <= in_a_i;
            b_q <= in_b_i;
            count_q <= count_d;
            tick_q <= tick ? 8'h00 : tick_q + 8'h01;
        end
    end
    // ----------------------------------------
    // Interval timer, 1 us resolution
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            us_q <= 32'h00000000;
            interval_q <= 32'h00000000;
        end else if (clear_i) begin
            us_q <= 32'h00000000;
            interval_q <= 32'h00000000;
        end else if (timer & ~hold & rise_a) begin
            interval_q <= us_q;
            us_q <= 32'h00000000;
        end else if (tick & ~hold & (us_q != 32'hFFFFFFFF)) begin
            us_q <= us_q + 32'h00000001;
        end
    end
    // ----------------------------------------
    // Count rate per window
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            win_q <= 32'h00000000;
            base_q <= 32'h00000000;
            rate_q <= 32'h00000000;
        end else if (tick) begin
            win_q <= win_end ? 32'h00000000 : win_q + 32'h00000001;
            if (win_end) begin
                rate_q <= count_q - base_q;
                base_q <= count_q;
            end
        end
    end
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            value_o <= 32'h00000000;
            scaled_o <= 32'h00000000;
            match_o <= 1'b0;
            active_o <= 1'b0;
        end else begin
            value_o <= timer ? interval_q : count_q;
            scaled_o <= prod[31 + `CIO_SCALE_SHIFT:`CIO_SCALE_SHIFT];
            match_o <= run_i & ~timer & (count_d == setpoint_i) & (count_d != count_q);
            active_o <= run_i & (func_w != FUNC_OFF) & ~inhibit_i;
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    inhibit_hold_a: assert property (run_i && inhibit_i && !clear_i |=> $stable(count_q))
        else $error("count moved while inhibited");
    setpoint_hit_a: assert property (match_o |-> count_q == $past(setpoint_i))
        else $error("match without setpoint equality");
endmodule
`default_nettype wire

// File: rtl/counter_io_status_logic.sv
`timescale 1ns/100ps
`default_nettype none
`include "counter_io_regs.svh"
// What this block does
// - Health/error indicators encode run, failure, program, self-test failure, unpowered.
// - Boot mode blinks health and error indicators together.
// - Watchdog timeout: health off, error steady on.
// - Channel indicator blinks while its first function counts or times.
// - Output indicators follow actual output state.
// - One indicator per input point shows its present state.
// - Inputs form two independent four-point channels, each with one common return.
// - Four isolated outputs, each discrete or pulse by configuration.
// - Input and output functions come only from the loaded configuration.
// - Counters accept quadrature, two encoders, with optional reset and inhibit inputs.
// - Counter reaching its setpoint activates assigned outputs without host action.
// - Asserted inhibit holds the counter and ignores pulses.
// - Timer measures pulse intervals, scaled internally to engineering units.
// - Position or rate scaling for counters, interval scaling for timers.
// - Host switches program and run modes; live monitoring only in run.
// - Output functions report runtime parameter transfer success or failure.
// - Host reads and writes internal registers; device services the accesses.
// - Four counter/timer resources, two per channel, up to 100 kHz.
// - Timers 32-bit at 1 us; counters signed, 31 bits plus sign.
module counter_io_status_logic
    import counter_io_pkg::*;
#(
    parameter int BLINK_CYCLES = `CIO_BLINK_HALF_MS * 1000 * `CIO_CLK_MHZ,
    parameter int WDT_CYCLES = `CIO_WDT_MS * 1000 * `CIO_CLK_MHZ
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [3:0] first_group_inputs_i,
    input wire logic [3:0] second_group_inputs_i,
    input wire logic hw_fault_i,
    input wire logic selftest_fail_i,
    output logic [3:0] output_points_o,
    output logic health_indicator_o,
    output logic error_indicator_o,
    output logic channel_one_activity_led_o,
    output logic channel_two_activity_led_o,
    output logic [7:0] input_leds_o,
    output logic [3:0] output_leds_o
);
    localparam int TICK_CYCLES = `CIO_TICK_NS / `CIO_CLK_NS;
    localparam int PULSE_CYCLES = `CIO_PULSE_US * TICK_CYCLES;
    localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYCLES - 1);
    localparam logic [31:0] WDT_LAST = 32'(WDT_CYCLES - 1);

    mode_t mode_q;
    logic [31:0] outcfg_q, blink_cnt_q, wdt_cnt_q;
    logic [31:0] cfg_q [4];
    logic [31:0] setpoint_q [4];
    logic [31:0] value_w [4];
    logic [31:0] scaled_w [4];
    logic [3:0] match_w, active_w, xfer_ok_q, xfer_err_q;
    logic blink_q, wdt_expired_q;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire acc_w = psel_i & penable_i & pready_o;
    wire early_w = psel_i & penable_i & ~pready_o;
    wire wr_w = acc_w & pwrite_i;
    wire aligned_w = paddr_i[1:0] == 2'h0;
    wire ctrl_hit_w = paddr_i == `CIO_CTRL_ADDR;
    wire status_hit_w = paddr_i == `CIO_STATUS_ADDR;
    wire wdog_hit_w = paddr_i == `CIO_WDOG_ADDR;
    wire outcfg_hit_w = paddr_i == `CIO_OUTCFG_ADDR;
    wire xfer_hit_w = paddr_i == `CIO_XFER_ADDR;
    wire res_hit_w = (paddr_i[11:6] == `CIO_RES_PAGE) & aligned_w;
    wire [1:0] res_idx_w = paddr_i[5:4];
    wire [1:0] res_reg_w = paddr_i[3:2];
    wire mapped_w = ctrl_hit_w | status_hit_w | wdog_hit_w | outcfg_hit_w | xfer_hit_w | res_hit_w;
    wire live_w = mode_q == MODE_RUN;
    wire run_w = live_w & ~wdt_expired_q;
    wire kick_w = wr_w & wdog_hit_w;
    wire wdt_clr_w = wr_w & ctrl_hit_w & pwdata_i[`CIO_CTRL_WDT_CLR];
    wire wdt_hit_w = live_w & ~kick_w & (wdt_cnt_q == WDT_LAST);
    wire outcfg_wr_w = wr_w & outcfg_hit_w;
    wire [1:0] cmd_w = pwdata_i[`CIO_CTRL_MODE];
    wire mode_t mode_cmd_w = cmd_w == `CIO_CMD_RUN ? MODE_RUN :
        cmd_w == `CIO_CMD_BOOT ? MODE_BOOT :
        cmd_w == `CIO_CMD_PROGRAM ? MODE_PROGRAM : mode_q;

    // Run-time values read as zero outside run mode
    wire [31:0] res_word_w = res_reg_w == `CIO_RES_CFG ? cfg_q[res_idx_w] :
        res_reg_w == `CIO_RES_SETPOINT ? setpoint_q[res_idx_w] :
        ~live_w ? 32'h00000000 :
        res_reg_w == `CIO_RES_VALUE ? value_w[res_idx_w] : scaled_w[res_idx_w];
    wire [31:0] status_w = {8'h00, output_points_o, second_group_inputs_i, first_group_inputs_i,
        active_w, 3'h0, selftest_fail_i, hw_fault_i, wdt_expired_q, mode_q};
    wire [31:0] rdata_w = ctrl_hit_w ? {30'h00000000, mode_q} :
        status_hit_w ? status_w :
        outcfg_hit_w ? outcfg_q :
        xfer_hit_w ? {24'h000000, xfer_err_q, xfer_ok_q} :
        res_hit_w ? res_word_w : 32'h00000000;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= early_w;
            pslverr_o <= early_w & ~mapped_w;
            if (early_w & ~pwrite_i) begin
                prdata_o <= rdata_w;
            end
        end
    end

    // ----------------------------------------
    // Mode, output configuration, watchdog
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode_q <= MODE_PROGRAM;
            outcfg_q <= `CIO_OUTCFG_RESET;
        end else begin
            if (wr_w & ctrl_hit_w) begin
                mode_q <= mode_cmd_w;
            end
            if (outcfg_wr_w & (mode_q != MODE_BOOT)) begin
                outcfg_q <= pwdata_i;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wdt_cnt_q <= 32'h00000000;
            wdt_expired_q <= 1'b0;
        end else begin
            wdt_cnt_q <= (kick_w | ~live_w | wdt_hit_w) ? 32'h00000000 : wdt_cnt_q + 32'h00000001;
            wdt_expired_q <= wdt_hit_w | (wdt_expired_q & ~wdt_clr_w);
        end
    end

    // ----------------------------------------
    // Counter/timer resources, two per channel
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_res
            localparam int GRP = i / 2;
            localparam int PA = (i % 2) * 2;
            wire [3:0] pins = GRP == 0 ? first_group_inputs_i : second_group_inputs_i;
            wire cfg_hit = wr_w & res_hit_w & (res_idx_w == 2'(i));
            wire inh = cfg_q[i][`CIO_CFG_INH_EN] & pins[cfg_q[i][`CIO_CFG_INH_PIN]];
            wire clr = cfg_q[i][`CIO_CFG_RST_EN] & pins[cfg_q[i][`CIO_CFG_RST_PIN]];
            always_ff @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    cfg_q[i] <= `CIO_CFG_RESET;
                    setpoint_q[i] <= `CIO_SETPOINT_RESET;
                end else begin
                    if (cfg_hit & (res_reg_w == `CIO_RES_CFG) & (mode_q == MODE_PROGRAM)) begin
                        cfg_q[i] <= pwdata_i;
                    end
                    if (cfg_hit & (res_reg_w == `CIO_RES_SETPOINT)) begin
                        setpoint_q[i] <= pwdata_i;
                    end
                end
            end
            counter_resource #(
                .TICK_CYCLES(TICK_CYCLES),
                .WINDOW_US(`CIO_RATE_WINDOW_US)
            ) u_res (
                .clock_i(clock_i),
                .reset_i(reset_i),
                .run_i(run_w),
                .func_i(cfg_q[i][`CIO_CFG_FUNC]),
                .rate_sel_i(cfg_q[i][`CIO_CFG_RATE]),
                .mult_i(cfg_q[i][`CIO_CFG_MULT]),
                .in_a_i(pins[PA]),
                .in_b_i(pins[PA + 1]),
                .inhibit_i(inh),
                .clear_i(clr),
                .setpoint_i(setpoint_q[i]),
                .value_o(value_w[i]),
                .scaled_o(scaled_w[i]),
                .match_o(match_w[i]),
                .active_o(active_w[i])
            );
        end
    endgenerate

    // ----------------------------------------
    // Output points
    // ----------------------------------------
    wire [3:0] drive_w;
    logic latch_q [4];
    logic [15:0] pulse_q [4];
    generate
        for (i = 0; i < 4; i++) begin : g_out
            wire [7:0] oc = outcfg_q[i * `CIO_OC_SLOT +: `CIO_OC_SLOT];
            wire [7:0] oc_new = pwdata_i[i * `CIO_OC_SLOT +: `CIO_OC_SLOT];
            wire hit = match_w[oc[`CIO_OC_SRC]];
            wire src_off = cfg_q[oc_new[`CIO_OC_SRC]][`CIO_CFG_FUNC] == FUNC_OFF;
            wire bad = (mode_q == MODE_BOOT) | (~oc_new[`CIO_OC_RAW_EN] & src_off);
            wire pulsed = pulse_q[i] != 16'h0000;
            assign drive_w[i] = ~run_w ? 1'b0 :
                oc[`CIO_OC_RAW_EN] ? oc[`CIO_OC_RAW_LVL] :
                oc[`CIO_OC_PULSE] ? pulsed : latch_q[i];
            always_ff @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    latch_q[i] <= 1'b0;
                    pulse_q[i] <= 16'h0000;
                    xfer_ok_q[i] <= 1'b0;
                    xfer_err_q[i] <= 1'b0;
                end else begin
                    latch_q[i] <= hit | (latch_q[i] & ~outcfg_wr_w);
                    if (hit & oc[`CIO_OC_PULSE]) begin
                        pulse_q[i] <= 16'(PULSE_CYCLES);
                    end else if (pulsed) begin
                        pulse_q[i] <= pulse_q[i] - 16'h0001;
                    end
                    if (outcfg_wr_w) begin
                        xfer_ok_q[i] <= ~bad;
                        xfer_err_q[i] <= bad;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Indicators
    // ----------------------------------------
    wire calm_w = ~wdt_expired_q & ~hw_fault_i & ~selftest_fail_i;
    wire run_calm_w = calm_w & (mode_q == MODE_RUN);
    wire boot_calm_w = calm_w & (mode_q == MODE_BOOT);
    wire ch1_act_w = active_w[0];
    wire ch2_act_w = active_w[2];
    wire health_d = wdt_expired_q ? 1'b0 : hw_fault_i ? 1'b1 : selftest_fail_i ? 1'b0 :
        run_calm_w ? 1'b1 : blink_q;
    wire error_d = wdt_expired_q | hw_fault_i | ((selftest_fail_i | boot_calm_w) & blink_q);
    wire blink_wrap_w = blink_cnt_q == BLINK_LAST;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            blink_cnt_q <= 32'h00000000;
            blink_q <= 1'b0;
        end else begin
            blink_cnt_q <= blink_wrap_w ? 32'h00000000 : blink_cnt_q + 32'h00000001;
            blink_q <= blink_q ^ blink_wrap_w;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            health_indicator_o <= 1'b0;
            error_indicator_o <= 1'b0;
            channel_one_activity_led_o <= 1'b0;
            channel_two_activity_led_o <= 1'b0;
            input_leds_o <= 8'h00;
            output_leds_o <= 4'h0;
            output_points_o <= 4'h0;
        end else begin
            health_indicator_o <= health_d;
            error_indicator_o <= error_d;
            channel_one_activity_led_o <= ch1_act_w & blink_q;
            channel_two_activity_led_o <= ch2_act_w & blink_q;
            input_leds_o <= {second_group_inputs_i, first_group_inputs_i};
            output_leds_o <= output_points_o;
            output_points_o <= drive_w;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence access_s;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence read_value_s;
        access_s and (!pwrite_i && res_hit_w && res_reg_w == `CIO_RES_VALUE && !live_w);
    endsequence
    apb_answer_a: assert property (setup_s ##1 access_s |=> pready_o)
        else $error("apb access not answered in one cycle");
    monitor_gate_a: assert property (read_value_s |=> prdata_o == 32'h00000000)
        else $error("live value visible outside run mode");
    run_leds_a: assert property ($past(run_calm_w) |-> health_indicator_o && !error_indicator_o)
        else $error("run indicator pattern wrong");
    boot_blink_a: assert property ($past(boot_calm_w) |->
        health_indicator_o == error_indicator_o && health_indicator_o == $past(blink_q))
        else $error("boot indicators not blinking together");
    wdt_leds_a: assert property ($past(wdt_expired_q) |-> !health_indicator_o && error_indicator_o)
        else $error("watchdog indicator pattern wrong");
    chan_led_a: assert property (channel_one_activity_led_o |-> $past(ch1_act_w))
        else $error("channel indicator blinks while idle");
    out_led_a: assert property (output_leds_o == $past(output_points_o))
        else $error("output indicator does not follow output");
    in_led_a: assert property (input_leds_o == $past({second_group_inputs_i, first_group_inputs_i}))
        else $error("input indicator does not follow input");
    xfer_fail_a: assert property (outcfg_wr_w && mode_q == MODE_BOOT |=>
        xfer_err_q == 4'hF && xfer_ok_q == 4'h0)
        else $error("transfer failure not flagged");
    blink_period_a: assert property ($changed(blink_q) |-> $past(blink_cnt_q) == BLINK_LAST)
        else $error("blink toggled off period");
endmodule
`default_nettype wire

// File: bench/field_encoder_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Quadrature encoder, eight clocks a pulse
// ----------------------------------------
module field_encoder_model (
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic [7:0] count_i,
    output logic a_o,
    output logic b_o,
    output var logic busy_o
);
    logic [7:0] left_q = 8'h00;
    logic [2:0] ph_q = 3'h0;
    logic busy_q = 1'b0;
    always @(posedge clock_i) begin
        if (go_i && !busy_q) begin
            left_q <= count_i;
            ph_q <= 3'h0;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == 3'h7) begin
                left_q <= left_q - 8'h01;
                busy_q <= (left_q != 8'h01);
            end
        end
    end
    // A leads B by a quarter period
    assign a_o = busy_q && (ph_q[2:1] == 2'h1 || ph_q[2:1] == 2'h2);
    assign b_o = busy_q && ph_q[2];
    assign busy_o = busy_q;
endmodule
`default_nettype wire

// File: bench/counter_io_status_logic_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module counter_io_status_logic_tb_top;
    logic clock_i, reset_i = 1, psel = 0, pen = 0, pwr = 0, hwf = 0, stf = 0, go = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, prd;
    logic [3:0] g2 = 0, outs, oled;
    logic [1:0] g1hi = 0;
    logic [7:0] rnd = 8'h21, iled;
    logic rdy, err, hl, el, c1, c2, ea, eb, eby;
    logic [64:0] notes[$];
    int fails = 0, cmp_count = 0, k, tg[4], neq;
    // ----------------------------------------
    // Instances and helpers
    // ----------------------------------------
    field_encoder_model enc_u (.clock_i(clock_i), .go_i(go), .count_i(8'h05), .a_o(ea), .b_o(eb), .busy_o(eby));
    counter_io_status_logic #(.BLINK_CYCLES(16), .WDT_CYCLES(4000)) dut_u (.clock_i(clock_i), .reset_i(reset_i),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(rdy), .pslverr_o(err), .first_group_inputs_i({g1hi, eb, ea}), .second_group_inputs_i(g2),
        .hw_fault_i(hwf), .selftest_fail_i(stf), .output_points_o(outs), .health_indicator_o(hl),
        .error_indicator_o(el), .channel_one_activity_led_o(c1), .channel_two_activity_led_o(c2),
        .input_leds_o(iled), .output_leds_o(oled));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task end_sim();
        $display("compared %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("mismatch %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clock_i);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            fails++;
            end_sim();
        end
        psel <= 0;
        pen <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic er);
        notes.push_back({er, m, e});
        apb(0, a, 0);
    endtask
    task watch(input int n);
        logic [3:0] p, q;
        p = {hl, el, c1, c2};
        neq = 0;
        tg = '{0, 0, 0, 0};
        repeat (n) begin
            @(posedge clock_i);
            #1;
            q = {hl, el, c1, c2};
            for (int i = 0; i < 4; i++) if (q[i] !== p[i]) tg[i]++;
            if (hl !== el) neq++;
            p = q;
        end
        @(posedge clock_i);
    endtask
    task spin();
        go <= 1;
        @(posedge clock_i);
        go <= 0;
        k = 0;
        do begin
            @(posedge clock_i);
            k++;
        end while (eby !== 1'b0 && k < 100);
        if (eby !== 1'b0) begin
            fails++;
            end_sim();
        end
        repeat (10) @(posedge clock_i);
    endtask
    always @(posedge clock_i) begin
        if (psel && pen && rdy === 1'b1 && !pwr) begin
            chk("rdata", notes[0][31:0], prd & notes[0][63:32]);
            chk("slverr", {31'b0, notes[0][64]}, {31'b0, err});
            void'(notes.pop_front());
        end
    end
    // ----------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------
    initial begin
        clock_i = 0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        #400000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clock_i);
        reset_i <= 0;
        watch(40);
        chk("prog_err", 0, 32'(el));
        chk("prog_blink", 1, 32'(tg[3] > 0));
        rd(12'h004, 0, 3, 0);
        rd(12'hFFC, 0, 32'hFFFFFFFF, 1);
        apb(1, 12'h040, 32'h01000072);
        apb(1, 12'h044, 32'h00000005);
        apb(1, 12'h00C, 32'h00000000);
        rd(12'h010, 32'h0000000F, 32'h000000FF, 0);
        apb(1, 12'h000, 32'h00000001);
        rd(12'h004, 1, 3, 0);
        watch(40);
        chk("run_led", 32'h2, {hl, el});
        chk("run_steady", 0, tg[3] + tg[2]);
        chk("ch1_blink", 1, 32'(tg[1] > 0));
        chk("ch2_idle", 0, tg[0]);
        $display("test modes done");
        repeat (4) begin
            rnd = lfsr(rnd);
            g2 <= rnd[3:0];
            g1hi <= rnd[5:4];
            repeat (3) @(posedge clock_i);
            chk("in_leds", {24'b0, rnd[3:0], rnd[5:4], 2'b00}, 32'(iled));
        end
        g1hi <= 0;
        spin();
        rd(12'h048, 5, 32'hFFFFFFFF, 0);
        rd(12'h04C, 5, 32'hFFFFFFFF, 0);
        chk("out_pt", 32'hF, 32'(outs));
        chk("out_led", 32'hF, 32'(oled));
        g1hi <= 2'b10;
        spin();
        rd(12'h048, 5, 32'hFFFFFFFF, 0);
        g1hi <= 0;
        $display("test count done");
        k = 0;
        while (el !== 1'b1 && k < 5000) begin
            @(posedge clock_i);
            k++;
        end
        if (el !== 1'b1) begin
            fails++;
            end_sim();
        end
        chk("wdt_leds", 32'h1, {hl, el});
        chk("wdt_outs", 0, 32'(outs));
        apb(1, 12'h000, 32'h00000101);
        apb(1, 12'h00C, 32'h00001018);
        hwf <= 1;
        repeat (3) @(posedge clock_i);
        chk("hw_leds", 32'h3, {hl, el});
        chk("raw_outs", 32'h1, 32'(outs));
        hwf <= 0;
        stf <= 1;
        repeat (2) @(posedge clock_i);
        watch(40);
        chk("st_health", 0, tg[3] + 32'(hl));
        chk("st_blink", 1, 32'(tg[2] > 0));
        stf <= 0;
        apb(1, 12'h000, 32'h00000002);
        watch(40);
        chk("boot_blink", 1, 32'(tg[3] > 0 && neq == 0));
        apb(1, 12'h00C, 32'h00000000);
        rd(12'h010, 32'h000000F0, 32'h000000FF, 0);
        rd(12'h048, 0, 32'hFFFFFFFF, 0);
        $display("test faults done");
        end_sim();
    end
endmodule
`default_nettype wire
